// File: gpsp_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module gpsp_ctrl_model (
	input wire logic clk_in,
	input wire logic rx_ready_in,
	input wire logic srq_oe_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_eoi_in,
	input wire logic tx_valid_in,
	output logic srq_n_out,
	output logic listen_out,
	output logic talk_out,
	output logic spoll_out,
	output logic [7:0] rx_data_out,
	output logic rx_eoi_out,
	output logic rx_valid_out,
	output var logic tx_ready_out
);
	logic other_req;
	logic [8:0] txq[$];
	int fail = 0;

	assign srq_n_out = !(srq_oe_in || other_req);

	initial begin
		other_req = 1'b0;
		listen_out = 1'b0;
		talk_out = 1'b0;
		spoll_out = 1'b0;
		rx_data_out = 8'h00;
		rx_eoi_out = 1'b0;
		rx_valid_out = 1'b0;
	end

	always @(negedge clk_in) begin
		tx_ready_out <= ($urandom % 4) != 0;
	end

	always @(posedge clk_in) begin
		if (tx_valid_in && tx_ready_out)
			txq.push_back({tx_eoi_in, tx_data_in});
	end

	task automatic listen();
		@(negedge clk_in);
		listen_out = 1'b1;
		@(negedge clk_in);
		listen_out = 1'b0;
	endtask

	task automatic send(input logic [7:0] b, input logic e);
		int n;
		rx_data_out = b;
		rx_eoi_out = e;
		rx_valid_out = 1'b1;
		for (n = 0; n < 400 && !rx_ready_in; n++)
			@(negedge clk_in);
		if (n == 400) begin
			fail++;
			$display("ERROR rx ready expected 1 seen 0");
		end
		@(negedge clk_in);
	endtask

	task automatic idle();
		rx_valid_out = 1'b0;
		rx_data_out = ~rx_data_out;
		rx_eoi_out = ~rx_eoi_out;
	endtask

	task automatic talk(input logic p);
		@(negedge clk_in);
		spoll_out = p;
		talk_out = 1'b1;
		@(negedge clk_in);
		talk_out = 1'b0;
	endtask

	task automatic set_other(input logic v);
		other_req = v;
	endtask
endmodule
`default_nettype wire

// File: gpsp_pkg.sv
package gpsp_pkg;
	localparam int FIFO_DEPTH = 16;
	localparam int EVQ_DEPTH = 17;
	localparam logic [4:0] EVQ_LAST = 5'h10;
	localparam logic [4:0] EVQ_FULL = 5'h11;
	localparam logic [2:0] MNEM_LAST = 3'h5;
	localparam logic [3:0] HDR_FIRST = 4'h6;
	localparam logic [3:0] HDR_CNT_HI = 4'h6;
	localparam logic [3:0] HDR_CNT_LO = 4'h7;
	localparam logic [3:0] HDR_LAST = 4'hb;
	localparam int RQS_BIT = 6;
	localparam logic [7:0] STB_OVF = 8'h7f;
	localparam logic [7:0] STB_IDLE = 8'h00;
	localparam logic [7:0] CH_NUL = 8'h00;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_LC_A = 8'h61;
	localparam logic [7:0] CH_LC_Z = 8'h7a;
	localparam logic [7:0] CASE_MASK = 8'hdf;
	localparam logic [7:0] PARITY_MASK = 8'h7f;

	typedef enum logic [1:0] {
		GPSP_TERM_EOI = 2'h0,
		GPSP_TERM_CR = 2'h1,
		GPSP_TERM_LF = 2'h2,
		GPSP_TERM_ETX = 2'h3
	} gpsp_term_t;

	typedef enum logic [1:0] {
		GPSP_FMT_ASCII = 2'h0,
		GPSP_FMT_SWITCH = 2'h1,
		GPSP_FMT_BINARY = 2'h2
	} gpsp_fmt_t;

	typedef struct packed {
		logic addr;
		logic eoi;
		logic [7:0] data;
	} gpsp_rxb_t;
endpackage

// File: gpsp_top.sv
// Overview of operation
// - Service request pin is open-drain, shared with other devices.
// - Talk address during poll mode sends one status byte only.
// - Status bit six set exactly while an event or overflow is pending, even with requests disabled.
// - Service request released once status byte taken.
// - Every stream starts with a six-character mnemonic.
// - Mnemonic ending in question mark selects next talk output.
// - Each talk address resends selected kind until a new query.
// - Output starts with mnemonic, space replacing question mark.
// - Surplus bytes are handshaken then discarded.
// - New mnemonic only after fresh listen address.
// - Binary streams end on byte count or EOI, no delimiters.
// - Binary header: mnemonic, two count bytes, four spare bytes.
// - Commas separate fields; input scanned, output fixed format.
// - Drop nulls and spaces, ignore parity bit.
// - Lower-case letters converted to upper case.
// - Binary values are byte, word or four-byte float.
// - Switch input only 1, 0, asterisk, else stream rejected.
// - ASCII streams end on terminator character or EOI.
// - Input terminator selectable: EOI, CR, LF or ETX.
// - Up to 17 queued events, one status byte per poll.
// - Queue overflow makes status byte 127.
`timescale 1ns/100ps
`default_nettype none

module gpsp_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic wr;
	logic rd;

	assign in_ready_out = (cnt_r != DEPTH[AW:0]);
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out = mem[rp_r];
	assign wr = in_valid_in & in_ready_out;
	assign rd = out_valid_out & out_ready_in;

	always_ff @(posedge clk_in) begin
		if (wr) begin
			mem[wp_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (wr) begin
				wp_r <= wp_r + 1'b1;
			end
			if (rd) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

module gpsp_top (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic SRQ_N_IN,
	output logic SRQ_N_OUT,
	output logic SRQ_OE_OUT,
	output logic SRQ_LINE_OUT,
	input wire logic SRQ_ENABLE_IN,
	input wire logic [1:0] TERM_SEL_IN,
	input wire logic LISTEN_ADDR_IN,
	input wire logic TALK_ADDR_IN,
	input wire logic SPOLL_MODE_IN,
	input wire logic [7:0] RX_DATA_IN,
	input wire logic RX_EOI_IN,
	input wire logic RX_VALID_IN,
	output logic RX_READY_OUT,
	output logic [47:0] MNEM_OUT,
	output logic MNEM_VALID_OUT,
	input wire logic [1:0] STREAM_FMT_IN,
	output logic [7:0] CHR_DATA_OUT,
	output logic CHR_SEP_OUT,
	output logic CHR_VALID_OUT,
	input wire logic CHR_READY_IN,
	output logic DONE_OUT,
	output logic DONE_OK_OUT,
	input wire logic EVENT_IN,
	input wire logic [5:0] EVENT_CAUSE_IN,
	output logic [47:0] OUT_KIND_OUT,
	output logic OUT_REQ_OUT,
	input wire logic [7:0] USR_DATA_IN,
	input wire logic USR_LAST_IN,
	input wire logic USR_VALID_IN,
	output logic USR_READY_OUT,
	output logic [7:0] BUS_TX_DATA_OUT,
	output logic BUS_TX_EOI_OUT,
	output logic BUS_TX_VALID_OUT,
	input wire logic BUS_TX_READY_IN
);
	typedef enum logic [6:0] {
		PS_IDLE = 7'h01,
		PS_MNEM = 7'h02,
		PS_FMT = 7'h04,
		PS_HDR = 7'h08,
		PS_BIN = 7'h10,
		PS_ASC = 7'h20,
		PS_DISC = 7'h40
	} gpsp_ps_t;

	typedef enum logic [3:0] {
		TS_IDLE = 4'h1,
		TS_STB = 4'h2,
		TS_HDR = 4'h4,
		TS_DATA = 4'h8
	} gpsp_ts_t;

	function automatic logic [7:0] gpsp_norm(input logic [7:0] b);
		logic [7:0] c;
		c = b & gpsp_pkg::PARITY_MASK;
		if (c >= gpsp_pkg::CH_LC_A && c <= gpsp_pkg::CH_LC_Z) begin
			c = c & gpsp_pkg::CASE_MASK;
		end
		return c;
	endfunction

	function automatic logic [4:0] gpsp_inc17(input logic [4:0] p);
		return (p == gpsp_pkg::EVQ_LAST) ? 5'h00 : p + 5'h01;
	endfunction

	gpsp_pkg::gpsp_rxb_t f_in;
	gpsp_pkg::gpsp_rxb_t f_out;
	gpsp_ps_t ps_r;
	gpsp_ts_t ts_r;
	gpsp_pkg::gpsp_fmt_t fmt_r;
	logic f_in_valid, f_in_ready, f_out_valid, pop, p_ready;
	logic addr_pend_r;
	logic srq_s1_r, srq_s2_r;
	logic [2:0] mcnt_r;
	logic [3:0] hcnt_r;
	logic [15:0] blen_r;
	logic reject_r;
	logic [47:0] sel_r;
	logic sel_valid_r;
	logic [7:0] b;
	logic is_term;
	logic [5:0] evq [gpsp_pkg::EVQ_DEPTH];
	logic [4:0] ev_wp_r, ev_rp_r, ev_cnt_r;
	logic ovf_r, pending, stb_take;
	logic [7:0] stb;
	logic [2:0] tcnt_r;
	logic end_now;

	assign b = gpsp_norm(f_out.data);

	always_comb begin
		case (gpsp_pkg::gpsp_term_t'(TERM_SEL_IN))
			gpsp_pkg::GPSP_TERM_CR: is_term = (b == gpsp_pkg::CH_CR);
			gpsp_pkg::GPSP_TERM_LF: is_term = (b == gpsp_pkg::CH_LF);
			gpsp_pkg::GPSP_TERM_ETX: is_term = (b == gpsp_pkg::CH_ETX);
			default: is_term = 1'b0;
		endcase
	end

	assign f_in.addr = addr_pend_r;
	assign f_in.eoi = RX_EOI_IN;
	assign f_in.data = RX_DATA_IN;
	assign f_in_valid = addr_pend_r | RX_VALID_IN;
	assign RX_READY_OUT = f_in_ready & ~addr_pend_r;

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			addr_pend_r <= 1'b0;
		end else if (LISTEN_ADDR_IN) begin
			addr_pend_r <= 1'b1;
		end else if (f_in_ready) begin
			addr_pend_r <= 1'b0;
		end
	end

	gpsp_fifo #(
		.WIDTH($bits(gpsp_pkg::gpsp_rxb_t)),
		.DEPTH(gpsp_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk_in(CLK_IN),
		.resetn_in(RESETN_IN),
		.in_data_in(f_in),
		.in_valid_in(f_in_valid),
		.in_ready_out(f_in_ready),
		.out_data_out(f_out),
		.out_valid_out(f_out_valid),
		.out_ready_in(p_ready)
	);

	assign p_ready = (ps_r != PS_FMT) & (~CHR_VALID_OUT | CHR_READY_IN);
	assign pop = f_out_valid & p_ready;
	assign end_now = f_out.eoi | (ps_r == PS_BIN && blen_r == 16'h0001);

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ps_r <= PS_IDLE;
			fmt_r <= gpsp_pkg::GPSP_FMT_ASCII;
			mcnt_r <= 3'h0;
			hcnt_r <= 4'h0;
			blen_r <= 16'h0000;
			reject_r <= 1'b0;
			MNEM_OUT <= 48'h0;
			MNEM_VALID_OUT <= 1'b0;
			sel_r <= 48'h0;
			sel_valid_r <= 1'b0;
			CHR_DATA_OUT <= 8'h00;
			CHR_SEP_OUT <= 1'b0;
			CHR_VALID_OUT <= 1'b0;
			DONE_OUT <= 1'b0;
			DONE_OK_OUT <= 1'b0;
		end else begin
			MNEM_VALID_OUT <= 1'b0;
			DONE_OUT <= 1'b0;
			if (CHR_READY_IN) begin
				CHR_VALID_OUT <= 1'b0;
			end
			if (ps_r == PS_FMT) begin
				fmt_r <= gpsp_pkg::gpsp_fmt_t'(STREAM_FMT_IN);
				hcnt_r <= gpsp_pkg::HDR_FIRST;
				ps_r <= (STREAM_FMT_IN == gpsp_pkg::GPSP_FMT_BINARY) ? PS_HDR : PS_ASC;
			end else if (pop && f_out.addr) begin
				ps_r <= PS_MNEM;
				mcnt_r <= 3'h0;
				reject_r <= 1'b0;
			end else if (pop) begin
				case (ps_r)
					PS_MNEM: begin
						if (b != gpsp_pkg::CH_NUL) begin
							MNEM_OUT <= {MNEM_OUT[39:0], b};
							mcnt_r <= mcnt_r + 3'h1;
							if (mcnt_r == gpsp_pkg::MNEM_LAST && b == gpsp_pkg::CH_QUERY) begin
								sel_r <= {MNEM_OUT[39:0], gpsp_pkg::CH_SP};
								sel_valid_r <= 1'b1;
								ps_r <= PS_DISC;
							end else if (mcnt_r == gpsp_pkg::MNEM_LAST) begin
								MNEM_VALID_OUT <= 1'b1;
								ps_r <= f_out.eoi ? PS_DISC : PS_FMT;
								DONE_OUT <= f_out.eoi;
								DONE_OK_OUT <= 1'b1;
							end else if (f_out.eoi) begin
								ps_r <= PS_DISC;
							end
						end else if (f_out.eoi) begin
							ps_r <= PS_DISC;
						end
					end
					PS_HDR: begin
						hcnt_r <= hcnt_r + 4'h1;
						if (hcnt_r == gpsp_pkg::HDR_CNT_HI) begin
							blen_r <= {f_out.data, blen_r[7:0]};
						end
						if (hcnt_r == gpsp_pkg::HDR_CNT_LO) begin
							blen_r <= {blen_r[15:8], f_out.data};
						end
						if (f_out.eoi || (hcnt_r == gpsp_pkg::HDR_LAST && blen_r == 16'h0)) begin
							DONE_OUT <= 1'b1;
							DONE_OK_OUT <= 1'b1;
							ps_r <= PS_DISC;
						end else if (hcnt_r == gpsp_pkg::HDR_LAST) begin
							ps_r <= PS_BIN;
						end
					end
					PS_BIN: begin
						// raw bytes, end on count or EOI
						CHR_DATA_OUT <= f_out.data;
						CHR_SEP_OUT <= 1'b0;
						CHR_VALID_OUT <= 1'b1;
						blen_r <= blen_r - 16'h1;
						if (end_now) begin
							DONE_OUT <= 1'b1;
							DONE_OK_OUT <= 1'b1;
							ps_r <= PS_DISC;
						end
					end
					PS_ASC: begin
						if (is_term) begin
							DONE_OUT <= 1'b1;
							DONE_OK_OUT <= ~reject_r;
							ps_r <= PS_DISC;
						end else begin
							if (b != gpsp_pkg::CH_NUL && b != gpsp_pkg::CH_SP) begin
								CHR_DATA_OUT <= b;
								CHR_SEP_OUT <= (b == gpsp_pkg::CH_COMMA);
								CHR_VALID_OUT <= 1'b1;
							end
							if (fmt_r == gpsp_pkg::GPSP_FMT_SWITCH && b != gpsp_pkg::CH_ONE &&
								b != gpsp_pkg::CH_ZERO && b != gpsp_pkg::CH_STAR &&
								b != gpsp_pkg::CH_COMMA && b != gpsp_pkg::CH_NUL &&
								b != gpsp_pkg::CH_SP) begin
								reject_r <= 1'b1;
							end
							if (f_out.eoi) begin
								DONE_OUT <= 1'b1;
								DONE_OK_OUT <= ~reject_r & ~(fmt_r == gpsp_pkg::GPSP_FMT_SWITCH &&
									b != gpsp_pkg::CH_ONE && b != gpsp_pkg::CH_ZERO &&
									b != gpsp_pkg::CH_STAR && b != gpsp_pkg::CH_COMMA &&
									b != gpsp_pkg::CH_NUL && b != gpsp_pkg::CH_SP);
								ps_r <= PS_DISC;
							end
						end
					end
					default: ps_r <= ps_r;
				endcase
			end
		end
	end

	assign pending = (ev_cnt_r != 5'h00) | ovf_r;
	assign stb = ovf_r ? gpsp_pkg::STB_OVF :
		(ev_cnt_r != 5'h00) ? {1'b0, 1'b1, evq[ev_rp_r]} : gpsp_pkg::STB_IDLE;
	assign stb_take = (ts_r == TS_STB) & BUS_TX_VALID_OUT & BUS_TX_READY_IN;

	always_ff @(posedge CLK_IN) begin
		if (EVENT_IN && (ev_cnt_r != gpsp_pkg::EVQ_FULL || stb_take)) begin
			evq[ev_wp_r] <= EVENT_CAUSE_IN;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ev_wp_r <= 5'h00;
			ev_rp_r <= 5'h00;
			ev_cnt_r <= 5'h00;
			ovf_r <= 1'b0;
		end else if (stb_take && ovf_r) begin
			ovf_r <= 1'b0;
			ev_rp_r <= ev_wp_r;
			ev_wp_r <= EVENT_IN ? gpsp_inc17(ev_wp_r) : ev_wp_r;
			ev_cnt_r <= 5'(EVENT_IN);
		end else begin
			if (EVENT_IN && ev_cnt_r == gpsp_pkg::EVQ_FULL && !stb_take) begin
				ovf_r <= 1'b1;
			end
			if (EVENT_IN && (ev_cnt_r != gpsp_pkg::EVQ_FULL || stb_take)) begin
				ev_wp_r <= gpsp_inc17(ev_wp_r);
			end
			if (stb_take && ev_cnt_r != 5'h00) begin
				ev_rp_r <= gpsp_inc17(ev_rp_r);
			end
			ev_cnt_r <= ev_cnt_r + 5'(EVENT_IN && (ev_cnt_r != gpsp_pkg::EVQ_FULL || stb_take))
				- 5'(stb_take && ev_cnt_r != 5'h00);
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			SRQ_OE_OUT <= 1'b0;
			SRQ_N_OUT <= 1'b0;
		end else begin
			SRQ_OE_OUT <= SRQ_ENABLE_IN & pending & ~stb_take;
			SRQ_N_OUT <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			srq_s1_r <= 1'b1;
			srq_s2_r <= 1'b1;
		end else begin
			srq_s1_r <= SRQ_N_IN;
			srq_s2_r <= srq_s1_r;
		end
	end
	assign SRQ_LINE_OUT = ~srq_s2_r;

	assign OUT_KIND_OUT = sel_r;
	assign USR_READY_OUT = (ts_r == TS_DATA) & (~BUS_TX_VALID_OUT | BUS_TX_READY_IN);

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ts_r <= TS_IDLE;
			tcnt_r <= 3'h0;
			OUT_REQ_OUT <= 1'b0;
			BUS_TX_DATA_OUT <= 8'h00;
			BUS_TX_EOI_OUT <= 1'b0;
			BUS_TX_VALID_OUT <= 1'b0;
		end else begin
			OUT_REQ_OUT <= 1'b0;
			if (BUS_TX_READY_IN) begin
				BUS_TX_VALID_OUT <= 1'b0;
			end
			case (ts_r)
				TS_IDLE: begin
					if (TALK_ADDR_IN && SPOLL_MODE_IN) begin
						ts_r <= TS_STB;
						BUS_TX_DATA_OUT <= stb;
						BUS_TX_EOI_OUT <= 1'b0;
						BUS_TX_VALID_OUT <= 1'b1;
					end else if (TALK_ADDR_IN && sel_valid_r) begin
						ts_r <= TS_HDR;
						tcnt_r <= 3'h0;
						OUT_REQ_OUT <= 1'b1;
					end
				end
				TS_STB: begin
					if (stb_take) begin
						ts_r <= TS_IDLE;
					end
				end
				TS_HDR: begin
					if (!BUS_TX_VALID_OUT || BUS_TX_READY_IN) begin
						BUS_TX_DATA_OUT <= sel_r[8'(47 - 8 * tcnt_r) -: 8];
						BUS_TX_EOI_OUT <= 1'b0;
						BUS_TX_VALID_OUT <= 1'b1;
						tcnt_r <= tcnt_r + 3'h1;
						if (tcnt_r == gpsp_pkg::MNEM_LAST) begin
							ts_r <= TS_DATA;
						end
					end
				end
				TS_DATA: begin
					if (USR_READY_OUT && USR_VALID_IN) begin
						BUS_TX_DATA_OUT <= USR_DATA_IN;
						BUS_TX_EOI_OUT <= USR_LAST_IN;
						BUS_TX_VALID_OUT <= 1'b1;
						if (USR_LAST_IN) begin
							ts_r <= TS_IDLE;
						end
					end
				end
				default: ts_r <= TS_IDLE;
			endcase
		end
	end

	AST_SRQ_DROP: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		stb_take |=> !SRQ_OE_OUT) else $error("request not released after poll");
	AST_RQS_BIT: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(ts_r == TS_STB && BUS_TX_VALID_OUT) |-> BUS_TX_DATA_OUT[gpsp_pkg::RQS_BIT] == pending)
		else $error("status bit six wrong");
	AST_STB_ONE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		stb_take |=> ts_r == TS_IDLE && !BUS_TX_VALID_OUT) else $error("more than one status byte");
	AST_OVF_VAL: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		$rose(ts_r == TS_STB) && $past(ovf_r) |-> BUS_TX_DATA_OUT == gpsp_pkg::STB_OVF)
		else $error("overflow status wrong");
	AST_EVQ_MAX: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		ev_cnt_r <= gpsp_pkg::EVQ_FULL) else $error("event queue overrun");
	AST_QUERY_SEL: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(pop && !f_out.addr && ps_r == PS_MNEM && mcnt_r == gpsp_pkg::MNEM_LAST &&
		b == gpsp_pkg::CH_QUERY) |=> sel_valid_r && sel_r[7:0] == gpsp_pkg::CH_SP && ps_r == PS_DISC)
		else $error("query did not select output");
	AST_DISCARD: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(ps_r == PS_DISC && pop && !f_out.addr) |=> ps_r == PS_DISC && !$rose(CHR_VALID_OUT))
		else $error("surplus byte took effect");
	AST_NEW_ADDR: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(pop && f_out.addr) |=> ps_r == PS_MNEM && mcnt_r == 3'h0) else $error("address lost");
	AST_UPPER: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(CHR_VALID_OUT && fmt_r != gpsp_pkg::GPSP_FMT_BINARY) |->
		!(CHR_DATA_OUT >= gpsp_pkg::CH_LC_A && CHR_DATA_OUT <= gpsp_pkg::CH_LC_Z) &&
		!CHR_DATA_OUT[7]) else $error("lower case or parity passed");
	AST_HDR_NOEOI: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(ts_r == TS_HDR) |=> !BUS_TX_EOI_OUT) else $error("EOI inside header");
endmodule

`default_nettype wire

// File: gpsp_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module gpsp_top_bench;
	logic clk, rst_n, srq_n, srq_oe, srq_line, srq_drv, srq_en, listen, talk, spoll;
	logic rx_eoi, rx_valid, rx_ready, mnem_valid, chr_sep, chr_valid, chr_ready, done, done_ok;
	logic event_v, out_req, usr_last, usr_valid, usr_ready, tx_eoi, tx_valid, tx_ready;
	logic [1:0] term_sel, fmt;
	logic [5:0] cause;
	logic [7:0] rx_data, chr_data, usr_data, tx_data;
	logic [47:0] mnem, out_kind, last_mnem;
	logic last_ok;
	logic [8:0] got[$];
	logic [7:0] lst[7] = '{8'h61, 8'h7a, 8'h20, 8'h00, 8'h2c, 8'h35, 8'h4b};
	logic [7:0] trm[4] = '{8'h00, 8'h0d, 8'h0a, 8'h03};
	int n_mismatch = 0;
	int comparisons = 0;
	int n_done = 0;
	int n_req = 0;

	gpsp_top u_dut (.CLK_IN(clk), .RESETN_IN(rst_n), .SRQ_N_IN(srq_n), .SRQ_N_OUT(srq_drv),
		.SRQ_OE_OUT(srq_oe), .SRQ_LINE_OUT(srq_line), .SRQ_ENABLE_IN(srq_en),
		.TERM_SEL_IN(term_sel), .LISTEN_ADDR_IN(listen), .TALK_ADDR_IN(talk),
		.SPOLL_MODE_IN(spoll), .RX_DATA_IN(rx_data), .RX_EOI_IN(rx_eoi), .RX_VALID_IN(rx_valid),
		.RX_READY_OUT(rx_ready), .MNEM_OUT(mnem), .MNEM_VALID_OUT(mnem_valid),
		.STREAM_FMT_IN(fmt), .CHR_DATA_OUT(chr_data), .CHR_SEP_OUT(chr_sep),
		.CHR_VALID_OUT(chr_valid), .CHR_READY_IN(chr_ready), .DONE_OUT(done),
		.DONE_OK_OUT(done_ok), .EVENT_IN(event_v), .EVENT_CAUSE_IN(cause),
		.OUT_KIND_OUT(out_kind), .OUT_REQ_OUT(out_req), .USR_DATA_IN(usr_data),
		.USR_LAST_IN(usr_last), .USR_VALID_IN(usr_valid), .USR_READY_OUT(usr_ready),
		.BUS_TX_DATA_OUT(tx_data), .BUS_TX_EOI_OUT(tx_eoi), .BUS_TX_VALID_OUT(tx_valid),
		.BUS_TX_READY_IN(tx_ready));

	gpsp_ctrl_model u_ctl (.clk_in(clk), .rx_ready_in(rx_ready), .srq_oe_in(srq_oe),
		.tx_data_in(tx_data), .tx_eoi_in(tx_eoi), .tx_valid_in(tx_valid), .srq_n_out(srq_n),
		.listen_out(listen), .talk_out(talk), .spoll_out(spoll), .rx_data_out(rx_data),
		.rx_eoi_out(rx_eoi), .rx_valid_out(rx_valid), .tx_ready_out(tx_ready));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (chr_valid && chr_ready)
			got.push_back({chr_sep, chr_data});
		if (done) begin
			n_done++;
			last_ok = done_ok;
		end
		if (mnem_valid)
			last_mnem = mnem;
		if (out_req)
			n_req++;
	end

	always @(negedge clk) begin
		chr_ready <= ($urandom % 3) != 0;
	end

	task automatic test_done();
		n_mismatch += u_ctl.fail;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [47:0] exp, input logic [47:0] seen);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_until(input int nc, input int nd, input int nt, input int nr);
		int k;
		for (k = 0; k < 400; k++) begin
			if (got.size() >= nc && n_done >= nd && u_ctl.txq.size() >= nt && n_req >= nr)
				break;
			@(negedge clk);
		end
		if (k == 400) begin
			n_mismatch++;
			$display("ERROR wait expected progress seen timeout");
			test_done();
		end
	endtask

	// Reference: parity off, upper case, drop NUL and space, comma as separator
	function automatic void ref_ascii(input logic [7:0] b[$], ref logic [8:0] q[$]);
		logic [7:0] c;
		foreach (b[i]) begin
			c = b[i] & 8'h7f;
			if (c >= 8'h61 && c <= 8'h7a)
				c = c - 8'h20;
			if (c == 8'h2c)
				q.push_back(9'h12c);
			else if (c != 8'h00 && c != 8'h20)
				q.push_back({1'b0, c});
		end
	endfunction

	task automatic stream(input logic [47:0] mn, input logic [7:0] b[$], input int ei);
		u_ctl.listen();
		for (int i = 0; i < 6; i++)
			u_ctl.send(mn[47 - 8 * i -: 8], 1'b0);
		foreach (b[i])
			u_ctl.send(b[i], i == ei);
		u_ctl.idle();
	endtask

	task automatic end_stream(input logic [8:0] e[$], input int d);
		logic [8:0] g;
		wait_until(e.size(), d + 1, 0, 0);
		repeat (30) @(negedge clk);
		check("done count", 48'(d + 1), 48'(n_done));
		check("done ok", 48'h1, 48'(last_ok));
		check("char count", 48'(e.size()), 48'(got.size()));
		foreach (e[i]) begin
			g = got.pop_front();
			check("char", 48'(e[i]), 48'(g));
		end
		got = {};
	endtask

	initial begin
		logic [7:0] b[$];
		logic [8:0] e[$];
		logic [7:0] cq[$];
		logic [8:0] g;
		logic [47:0] kind;
		int d, nev, i;
		void'($urandom(32'h79a5964c));
		rst_n = 1'b0;
		srq_en = 1'b1;
		term_sel = 2'h0;
		fmt = 2'h0;
		event_v = 1'b0;
		cause = 6'h00;
		usr_data = 8'h00;
		usr_last = 1'b0;
		usr_valid = 1'b0;
		last_ok = 1'b0;
		last_mnem = 48'h0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		// Query then two talks with identical header
		b = {};
		kind = "WAVEA ";
		stream("WAVEA?", b, -1);
		repeat (4) @(negedge clk);
		check("out kind", kind, out_kind);
		for (int k = 0; k < 2; k++) begin
			e = {};
			for (i = 0; i < 6; i++)
				e.push_back({1'b0, kind[47 - 8 * i -: 8]});
			u_ctl.talk(1'b0);
			wait_until(0, 0, 0, k + 1);
			for (i = 0; i < 3; i++) begin
				usr_data = 8'($urandom);
				usr_last = (i == 2);
				usr_valid = 1'b1;
				e.push_back({usr_last, usr_data});
				for (d = 0; d < 200; d++) begin
					@(posedge clk);
					if (usr_ready)
						break;
				end
				if (d == 200) begin
					n_mismatch++;
					$display("ERROR usr ready expected 1 seen 0");
					test_done();
				end
				@(negedge clk);
			end
			usr_valid = 1'b0;
			wait_until(0, 0, 9, 0);
			foreach (e[j])
				check("talk byte", 48'(e[j]), 48'(u_ctl.txq.pop_front()));
		end
		// ASCII streams, each terminator mode, surplus after end
		for (int t = 0; t < 4; t++) begin
			b = {};
			e = {};
			for (i = 0; i < 5; i++)
				b.push_back(lst[$urandom % 7] | ((($urandom % 2) != 0) ? 8'h80 : 8'h00));
			b.push_back(8'h37);
			ref_ascii(b, e);
			if (t != 0)
				b.push_back(trm[t]);
			b = {b, 8'h54, 8'h49, 8'h4d, 8'h45, 8'h20, 8'h20};
			term_sel = 2'(t);
			d = n_done;
			stream("SETUP ", b, (t == 0) ? 5 : -1);
			end_stream(e, d);
			check("mnemonic", "SETUP ", last_mnem);
		end
		// Switch streams: accepted, then rejected
		fmt = 2'h1;
		term_sel = 2'h0;
		for (int s = 0; s < 2; s++) begin
			if (s == 0)
				b = {8'h31, 8'h30, 8'h2a, 8'h2c, 8'h31};
			else
				b = {8'h31, 8'h30, 8'h78, 8'h31};
			d = n_done;
			stream("FLAGS ", b, b.size() - 1);
			wait_until(0, d + 1, 0, 0);
			repeat (30) @(negedge clk);
			check("switch ok", 48'(s == 0), 48'(last_ok));
			got = {};
		end
		// binary header, count ends block, no terminators
		fmt = 2'h2;
		term_sel = 2'h1;
		b = {8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0d, 8'h03, 8'he1, 8'h0a, 8'h55, 8'h66};
		e = {9'h00d, 9'h003, 9'h0e1, 9'h00a};
		d = n_done;
		stream("BLOCK ", b, -1);
		end_stream(e, d);
		// Event queue, normal and overflow
		for (int k = 0; k < 3; k++) begin
			nev = (k == 0) ? 3 : 17 + k - 1;
			cq = {};
			for (i = 0; i < nev; i++) begin
				cause = 6'($urandom);
				event_v = 1'b1;
				cq.push_back({2'b01, cause});
				@(negedge clk);
			end
			event_v = 1'b0;
			if (nev > 17)
				cq = {8'h7f};
			repeat (3) @(negedge clk);
			check("srq drive", 48'h1, 48'(srq_oe));
			d = cq.size();
			for (i = 0; i < 20 && !srq_n; i++) begin
				u_ctl.talk(1'b1);
				wait_until(0, 0, 1, 0);
				g = u_ctl.txq.pop_front();
				check("status byte", 48'({1'b0, cq.pop_front()}), 48'(g));
				repeat (2) @(negedge clk);
			end
			check("poll count", 48'(d), 48'(i));
			u_ctl.talk(1'b1);
			wait_until(0, 0, 1, 0);
			check("idle status", 48'h0, 48'(u_ctl.txq.pop_front()));
		end
		// another device pulls the shared wire
		u_ctl.set_other(1'b1);
		repeat (4) @(negedge clk);
		check("line seen", 48'h1, 48'(srq_line));
		check("drive level", 48'h0, 48'({srq_drv, srq_oe}));
		u_ctl.set_other(1'b0);
		repeat (4) @(negedge clk);
		check("line free", 48'h0, 48'(srq_line));
		// requests gated off, event still queued
		srq_en = 1'b0;
		cause = 6'($urandom);
		event_v = 1'b1;
		@(negedge clk);
		event_v = 1'b0;
		repeat (3) @(negedge clk);
		check("srq gated", 48'h0, 48'(srq_oe));
		u_ctl.talk(1'b1);
		wait_until(0, 0, 1, 0);
		check("gated status", 48'({2'b01, cause}), 48'(u_ctl.txq.pop_front()));
		test_done();
	end
endmodule
`default_nettype wire
